// ### common/ssas_pkg.sv
// Behaviour
// - All selected channels are held together at one instant before any is digitized.
// - Acquisition lasts 20 clock cycles whatever the group size.
// - Each channel conversion takes 40 clock cycles.
// - Groups of two, three or four held channels convert one after another.
// - Each channel has its own result register, readable in any order.
// - Results are 11 bits wide in twos complement.
// - Busy output is low for 40 cycles per channel; rising means results updated.
// - Trigger is asynchronous; acquisition starts on the edge after two synchronised samples see it high.
// - Group select 00:in2,in3; 01:+aux; 10:in1-in3; 11:in1-in3 plus aux.
package ssas_pkg;
   localparam int RES_W = 11;
   localparam int ACQ_CYCLES = 20;
   localparam int CONV_CYCLES = 40;
   localparam int SAR_STEP = 3;
   localparam logic [5:0] ACQ_LAST = 6'h13;
   localparam logic [5:0] CONV_LAST = 6'h27;
   localparam logic [1:0] STEP_LAST = 2'h2;
   localparam logic [1:0] CH_IN1 = 2'h0;
   localparam logic [1:0] CH_IN2 = 2'h1;
   localparam logic [1:0] CH_IN3 = 2'h2;
   localparam logic [1:0] CH_AUX = 2'h3;
   localparam logic [7:0] OFS_RESULT0 = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFS_CTRL = 8'h1c;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_OVR_BIT = 1;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;
   localparam logic CTRL_EN_RST = 1'b1;
   typedef enum logic [1:0] {S_IDLE, S_ACQ, S_CONV} ssas_state_e;
endpackage

// ### rtl/ssas_sar.sv
`timescale 1ns/10ps
module ssas_sar #(
   parameter int RES_W = ssas_pkg::RES_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic cmp_in,
   output logic [RES_W-1:0] dac_code,
   output logic [RES_W-1:0] result,
   output logic done
);
   logic running_q;
   logic [5:0] cnt_q;
   logic [1:0] step_q;
   logic [3:0] bitpos_q;
   logic [RES_W-1:0] dac_q;
   logic trials_left;

   assign trials_left = (bitpos_q != 4'hf);
   assign done = running_q && (cnt_q == ssas_pkg::CONV_LAST);
   assign dac_code = dac_q;
   // Offset binary from the DAC becomes twos complement by flipping the sign bit.
   assign result = {~dac_q[RES_W-1], dac_q[RES_W-2:0]};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         running_q <= 1'b0;
         cnt_q <= 6'h00;
      end
      else if (start)
      begin
         running_q <= 1'b1;
         cnt_q <= 6'h00;
      end
      else if (done)
      begin
         running_q <= 1'b0;
      end
      else if (running_q)
      begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   // One bit trial every three cycles; the slack at the end keeps the 40 cycle frame.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         step_q <= 2'h0;
         bitpos_q <= 4'hf;
         dac_q <= '0;
      end
      else if (start)
      begin
         step_q <= 2'h1;
         bitpos_q <= 4'(RES_W - 1);
         dac_q <= '0;
         dac_q[RES_W-1] <= 1'b1;
      end
      else if (running_q && trials_left)
      begin
         if (step_q == ssas_pkg::STEP_LAST)
         begin
            step_q <= 2'h0;
            bitpos_q <= bitpos_q - 4'h1;
            if (!cmp_in)
            begin
               dac_q[bitpos_q] <= 1'b0;
            end
         end
         else
         begin
            step_q <= step_q + 2'h1;
            if (step_q == 2'h0)
            begin
               dac_q[bitpos_q] <= 1'b1;
            end
         end
      end
   end

   property p_conv_len;
      @(posedge pclk) disable iff (!presetn)
      start |-> ##40 done;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion did not take 40 cycles");

   property p_trials_done;
      @(posedge pclk) disable iff (!presetn)
      done |-> !trials_left;
   endproperty
   a_trials_done: assert property (p_trials_done) else $error("bit trials not finished within the frame");
endmodule // ssas_sar

// ### rtl/ssas_sequencer.sv
`timescale 1ns/10ps
module ssas_sequencer #(
   parameter int RES_W = ssas_pkg::RES_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_trigger,
   input wire logic group_select_lsb,
   input wire logic group_select_msb,
   input wire logic aux_select_lsb,
   input wire logic aux_select_msb,
   input wire logic cmp_in,
   output logic [RES_W-1:0] dac_code,
   output logic hold_en,
   output logic [1:0] chan_sel,
   output logic [1:0] aux_sel,
   output logic busy_n,
   output logic irq
);
   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [4:0] pin_s1_q;
   logic [4:0] pin_s2_q;
   logic [4:0] pin_s3_q;
   logic [4:0] pin_lvl_q;
   logic trig_rise;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_s1_q <= 5'h00;
         pin_s2_q <= 5'h00;
         pin_s3_q <= 5'h00;
         pin_lvl_q <= 5'h00;
      end
      else
      begin
         pin_s1_q <= {aux_select_msb, aux_select_lsb, group_select_msb, group_select_lsb, sample_trigger};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         pin_lvl_q <= (pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q ^ pin_s3_q));
      end
   end

   // A new trigger level counts once the two late stages agree, filtering single-sample glitches.
   assign trig_rise = pin_s2_q[0] && pin_s3_q[0] && !pin_lvl_q[0];

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   function automatic logic [1:0] first_chan(input logic [1:0] grp);
      first_chan = grp[1] ? ssas_pkg::CH_IN1 : ssas_pkg::CH_IN2;
   endfunction

   function automatic logic [1:0] last_chan(input logic [1:0] grp);
      last_chan = grp[0] ? ssas_pkg::CH_AUX : ssas_pkg::CH_IN3;
   endfunction

   function automatic logic [7:0] group_cycles(input logic [1:0] grp);
      group_cycles = 8'(ssas_pkg::CONV_CYCLES * (2 + int'(grp[1]) + int'(grp[0])));
   endfunction

   ssas_pkg::ssas_state_e state_q;
   logic [5:0] cnt_q;
   logic [1:0] grp_q;
   logic [1:0] chan_q;
   logic [1:0] aux_q;
   logic busy_n_q;
   logic hold_q;
   logic ctrl_en_q;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   logic [RES_W-1:0] result_q [4];
   logic sar_start;
   logic sar_done;
   logic [RES_W-1:0] sar_result;
   logic acq_end;
   logic last_done;
   logic start_ok;

   assign acq_end = (state_q == ssas_pkg::S_ACQ) && (cnt_q == ssas_pkg::ACQ_LAST);
   assign last_done = sar_done && (chan_q == last_chan(grp_q));
   assign sar_start = acq_end || (sar_done && !last_done);
   assign start_ok = trig_rise && ctrl_en_q && (state_q == ssas_pkg::S_IDLE);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ssas_pkg::S_IDLE;
         cnt_q <= 6'h00;
      end
      else
      begin
         unique case (state_q)
            ssas_pkg::S_IDLE:
            begin
               cnt_q <= 6'h00;
               if (start_ok)
               begin
                  state_q <= ssas_pkg::S_ACQ;
               end
            end
            ssas_pkg::S_ACQ:
            begin
               cnt_q <= cnt_q + 6'h01;
               if (acq_end)
               begin
                  state_q <= ssas_pkg::S_CONV;
               end
            end
            ssas_pkg::S_CONV:
            begin
               if (last_done)
               begin
                  state_q <= ssas_pkg::S_IDLE;
               end
            end
         endcase
      end
   end

   // Selects are taken at the trigger, so later pin changes cannot disturb a running group.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         grp_q <= 2'h0;
         aux_q <= 2'h0;
         chan_q <= ssas_pkg::CH_IN2;
      end
      else if (start_ok)
      begin
         grp_q <= pin_lvl_q[2:1];
         aux_q <= pin_lvl_q[4:3];
         chan_q <= first_chan(pin_lvl_q[2:1]);
      end
      else if (sar_done && !last_done)
      begin
         chan_q <= chan_q + 2'h1;
      end
   end

   // All inputs freeze together at the end of acquisition and stay held for the whole group.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hold_q <= 1'b0;
         busy_n_q <= 1'b1;
      end
      else if (acq_end)
      begin
         hold_q <= 1'b1;
         busy_n_q <= 1'b0;
      end
      else if (last_done)
      begin
         hold_q <= 1'b0;
         busy_n_q <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < 4; i++)
         begin
            result_q[i] <= '0;
         end
      end
      else if (sar_done)
      begin
         result_q[chan_q] <= sar_result;
      end
   end

   ssas_sar #(
      .RES_W(RES_W)
   ) u_sar (
      .pclk(pclk),
      .presetn(presetn),
      .start(sar_start),
      .cmp_in(cmp_in),
      .dac_code(dac_code),
      .result(sar_result),
      .done(sar_done)
   );

   assign hold_en = hold_q;
   assign chan_sel = chan_q;
   assign aux_sel = aux_q;
   assign busy_n = busy_n_q;

   // ****************************************************************
   // APB slave and interrupts
   // ****************************************************************
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic [1:0] irq_set;

   assign pready = 1'b1;
   assign mapped = (paddr[1:0] == 2'h0) && (paddr <= ssas_pkg::OFS_CTRL);
   assign pslverr = psel && penable && !mapped;
   assign wr_en = psel && penable && pwrite && mapped;
   assign rd_en = psel && !penable && !pwrite;
   assign irq_set = {start_ok ? 1'b0 : (trig_rise && (state_q != ssas_pkg::S_IDLE)), last_done};
   assign irq = |(irq_stat_q & irq_mask_q);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_q <= 2'h0;
         irq_mask_q <= ssas_pkg::IRQ_MASK_RST;
         ctrl_en_q <= ssas_pkg::CTRL_EN_RST;
      end
      else
      begin
         if (wr_en && (paddr == ssas_pkg::OFS_IRQ_STAT))
         begin
            irq_stat_q <= (irq_stat_q & ~pwdata[1:0]) | irq_set;
         end
         else
         begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
         if (wr_en && (paddr == ssas_pkg::OFS_IRQ_MASK))
         begin
            irq_mask_q <= pwdata[1:0];
         end
         if (wr_en && (paddr == ssas_pkg::OFS_CTRL))
         begin
            ctrl_en_q <= pwdata[0];
         end
      end
   end

   // Read data is captured in the setup cycle so it stands stable through the access cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (rd_en)
      begin
         prdata <= 32'h0000_0000;
         if (paddr < ssas_pkg::OFS_STATUS && paddr[1:0] == 2'h0)
         begin
            prdata[RES_W-1:0] <= result_q[paddr[3:2]];
         end
         else if (paddr == ssas_pkg::OFS_STATUS)
         begin
            prdata[7:0] <= {aux_q, grp_q, chan_q, hold_q, !busy_n_q};
         end
         else if (paddr == ssas_pkg::OFS_IRQ_STAT)
         begin
            prdata[1:0] <= irq_stat_q;
         end
         else if (paddr == ssas_pkg::OFS_IRQ_MASK)
         begin
            prdata[1:0] <= irq_mask_q;
         end
         else if (paddr == ssas_pkg::OFS_CTRL)
         begin
            prdata[0] <= ctrl_en_q;
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic in_acq;
   logic in_conv;
   logic [7:0] busy_len_q;

   assign in_acq = (state_q == ssas_pkg::S_ACQ);
   assign in_conv = (state_q == ssas_pkg::S_CONV);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         busy_len_q <= 8'h00;
      end
      else if (busy_n_q)
      begin
         busy_len_q <= 8'h00;
      end
      else
      begin
         busy_len_q <= busy_len_q + 8'h01;
      end
   end

   property p_acq_len;
      @(posedge pclk) disable iff (!presetn)
      $rose(in_conv) |-> $past(in_acq, 20) && !$past(in_acq, 21);
   endproperty
   a_acq_len: assert property (p_acq_len) else $error("acquisition was not 20 cycles");

   property p_hold_all;
      @(posedge pclk) disable iff (!presetn)
      hold_en == in_conv;
   endproperty
   a_hold_all: assert property (p_hold_all) else $error("inputs not held during conversion");

   property p_busy_len;
      @(posedge pclk) disable iff (!presetn)
      $rose(busy_n) |-> busy_len_q == group_cycles(grp_q);
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy low time wrong for group");

   property p_first_chan;
      @(posedge pclk) disable iff (!presetn)
      $rose(in_conv) |-> chan_sel == first_chan(grp_q);
   endproperty
   a_first_chan: assert property (p_first_chan) else $error("wrong first channel for group");

   property p_last_chan;
      @(posedge pclk) disable iff (!presetn)
      $fell(in_conv) |-> $past(chan_q) == last_chan(grp_q);
   endproperty
   a_last_chan: assert property (p_last_chan) else $error("group ended on wrong channel");

   property p_result_store;
      @(posedge pclk) disable iff (!presetn)
      sar_done |=> result_q[$past(chan_q)] == $past(sar_result);
   endproperty
   a_result_store: assert property (p_result_store) else $error("result not stored in its register");

   property p_trig_start;
      @(posedge pclk) disable iff (!presetn)
      (trig_rise && ctrl_en_q && !in_acq && !in_conv) |=> in_acq && busy_n_q;
   endproperty
   a_trig_start: assert property (p_trig_start) else $error("trigger did not start acquisition");

   property p_acq_cause;
      @(posedge pclk) disable iff (!presetn)
      $rose(in_acq) |-> $past(trig_rise);
   endproperty
   a_acq_cause: assert property (p_acq_cause) else $error("acquisition started without trigger");

   property p_twos;
      @(posedge pclk) disable iff (!presetn)
      sar_done |=> result_q[$past(chan_q)][RES_W-1] == !$past(dac_code[RES_W-1]);
   endproperty
   a_twos: assert property (p_twos) else $error("stored result not twos complement");

   c_full_group: cover property (@(posedge pclk) disable iff (!presetn) $fell(in_conv) && grp_q == 2'h3);
   c_two_group: cover property (@(posedge pclk) disable iff (!presetn) $fell(in_conv) && grp_q == 2'h0);
   c_overrun: cover property (@(posedge pclk) disable iff (!presetn) irq_set[1]);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule // ssas_sequencer

// ### tb/ssas_front_model.sv
`timescale 1ns/10ps
// ****************************************
// Held analog inputs and comparator
// ****************************************
// Each input sits half a step above its code, so the comparator decision never
// hangs on an exact tie and the converted code equals the held code.
module ssas_front_model (
   input wire logic hold_en,
   input wire logic [1:0] chan_sel,
   input wire logic [1:0] aux_sel,
   input wire logic [10:0] dac_code,
   input wire logic [6:0][10:0] live_codes,
   output logic cmp_in
);
   logic [3:0][10:0] held_q;

   // All four channels are frozen by the same event.
   always @(posedge hold_en)
   begin
      held_q[0] <= live_codes[0];
      held_q[1] <= live_codes[1];
      held_q[2] <= live_codes[2];
      held_q[3] <= live_codes[{1'b0, aux_sel} + 3'h3];
   end

   // While tracking, the comparator sees the live input, which keeps moving.
   assign cmp_in = (hold_en ? held_q[chan_sel] : live_codes[{1'b0, chan_sel}]) >= dac_code;
endmodule // ssas_front_model

// ### tb/ssas_sequencer_bench.sv
`timescale 1ns/10ps
module ssas_sequencer_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sample_trigger = 1'b0;
   logic [1:0] group_sel = 2'h0;
   logic [1:0] aux_pins = 2'h0;
   logic cmp_in;
   logic [10:0] dac_code;
   logic hold_en;
   logic [1:0] chan_sel;
   logic [1:0] aux_sel;
   logic busy_n;
   logic irq;
   logic [6:0][10:0] live_codes = '0;
   logic [6:0][10:0] held_codes;
   logic [31:0] rd;
   logic err;
   logic [1:0] first;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   int acq;
   int low;
   int n;

   always #2 pclk = ~pclk;

   ssas_sequencer i_ssas_sequencer (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_trigger(sample_trigger), .group_select_lsb(group_sel[0]), .group_select_msb(group_sel[1]),
      .aux_select_lsb(aux_pins[0]), .aux_select_msb(aux_pins[1]), .cmp_in(cmp_in),
      .dac_code(dac_code), .hold_en(hold_en), .chan_sel(chan_sel), .aux_sel(aux_sel),
      .busy_n(busy_n), .irq(irq)
   );

   ssas_front_model i_ssas_front_model (
      .hold_en(hold_en), .chan_sel(chan_sel), .aux_sel(aux_sel), .dac_code(dac_code),
      .live_codes(live_codes), .cmp_in(cmp_in)
   );

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_cnt(input string what, input int exp, input int got);
      checks++;
      if (got != exp)
      begin
         mismatches++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // The whole run is near 760 cycles, so the ceiling leaves ample margin.
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         end_sim();
      end
   end

   // ****************************************
   // Bus access
   // ****************************************
   // Only the cycle ceiling ends a wait; the master holds the access cycle until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the edge that completed the write settle before any caller looks at outputs.
      #1;
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      check_val("busy_n", 32'h1, {31'h0, busy_n});
      check_val("hold_en", 32'h0, {31'h0, hold_en});
      check_val("irq", 32'h0, {31'h0, irq});
      apb(1'b0, ssas_pkg::OFS_IRQ_MASK, 32'h0);
      check_val("mask", 32'h0, rd);
      apb(1'b0, ssas_pkg::OFS_CTRL, 32'h0);
      check_val("ctrl", 32'h1, rd);
      apb(1'b0, 8'h20, 32'h0);
      check_val("unmapped", 32'h1, {31'h0, err});
      check_val("unmapped data", 32'h0, rd);
      apb(1'b1, 8'h02, 32'h1);
      check_val("unaligned", 32'h1, {31'h0, err});
      apb(1'b1, ssas_pkg::OFS_IRQ_MASK, 32'h1);
      for (int g = 0; g < 4; g++)
      begin
         n = 2 + (g & 1) + (g >> 1);
         first = (g >= 2) ? 2'h0 : 2'h1;
         for (int i = 0; i < 7; i++)
            held_codes[i] = 11'(g * 300 + i * 277 + 5);
         if (g == 3)
         begin
            held_codes[0] = 11'h000;
            held_codes[6] = 11'h7ff;
         end
         @(posedge pclk);
         group_sel <= 2'(g);
         aux_pins <= 2'(g);
         live_codes <= held_codes;
         repeat (8) @(posedge pclk);
         sample_trigger <= 1'b1;
         acq = 0;
         do
         begin
            @(posedge pclk);
            #1;
            acq++;
         end while (busy_n !== 1'b0 && acq < 100);
         check_cnt("start delay", 4 + ssas_pkg::ACQ_CYCLES, acq);
         low = 1;
         check_val("chan", 32'(first), 32'(chan_sel));
         // Inputs move once held, and g 3 retriggers mid-conversion.
         while (busy_n === 1'b0 && low < 200)
         begin
            @(posedge pclk);
            sample_trigger <= (g == 3 && low >= 60 && low < 66);
            live_codes <= ~held_codes;
            #1;
            if (busy_n === 1'b0)
            begin
               low++;
               if (low % 40 == 1)
               begin
                  check_val("chan", 32'(first) + 32'(low / 40), 32'(chan_sel));
                  check_val("hold_en", 32'h1, {31'h0, hold_en});
               end
            end
         end
         check_cnt("busy width", n * 40, low);
         check_val("irq", 32'h1, {31'h0, irq});
         for (int c = 3; c >= 0; c--)
         begin
            if (c >= int'(first) && c < int'(first) + n)
            begin
               apb(1'b0, 8'(4 * c), 32'h0);
               check_val("result", 32'(held_codes[c == 3 ? 3 + g : c] ^ 11'h400), rd);
            end
         end
         apb(1'b0, ssas_pkg::OFS_IRQ_STAT, 32'h0);
         check_val("irq status", (g == 3) ? 32'h3 : 32'h1, rd);
         apb(1'b0, ssas_pkg::OFS_STATUS, 32'h0);
         check_val("status", 32'(g * 80 + (int'(first) + n - 1) * 4), rd);
         if (g == 0)
         begin
            apb(1'b1, ssas_pkg::OFS_IRQ_MASK, 32'h0);
            check_val("masked irq", 32'h0, {31'h0, irq});
            apb(1'b1, ssas_pkg::OFS_IRQ_MASK, 32'h3);
         end
         apb(1'b1, ssas_pkg::OFS_IRQ_STAT, 32'h3);
         check_val("cleared irq", 32'h0, {31'h0, irq});
      end
      // A disabled sequencer must ignore the trigger altogether.
      apb(1'b1, ssas_pkg::OFS_CTRL, 32'h0);
      @(posedge pclk);
      sample_trigger <= 1'b1;
      repeat (40) @(posedge pclk);
      sample_trigger <= 1'b0;
      #1;
      check_val("disabled busy_n", 32'h1, {31'h0, busy_n});
      apb(1'b1, ssas_pkg::OFS_CTRL, 32'h1);
      end_sim();
   end
endmodule // ssas_sequencer_bench
